// [hdl/astc_top.sv]
// converter trigger, channel sequencing and result control with AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module astc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_trigger_n,
    input wire logic timer16_underflow,
    input wire logic [9:0] analog_result,
    output logic [2:0] analog_chan,
    output logic analog_sample,
    output logic analog_convert
);
    logic [3:0] clk_div_sel;
    astc_pkg::astc_cfg_s cfg;
    logic conv_enable;
    logic conv_start_busy;
    logic conv_done_flag;
    logic overwrite_err_flag;
    logic [15:0] result_data;
    logic [2:0] cur_chan;
    astc_pkg::astc_state_e state;
    logic [3:0] phase_cnt;
    logic tick;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic wr_ctrl;
    logic rd_data;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic trigger;
    logic sw_start;
    logic sw_stop;
    logic seq_last;
    logic [9:0] store_val;
    logic [15:0] next_result;

    // bus address phase capture
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready)
        begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_ctrl = ph_valid && ph_write && ph_addr == astc_pkg::OFF_CTRL;
    assign rd_data = ph_valid && !ph_write && ph_addr == astc_pkg::OFF_DATA;

    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ph_valid && !ph_write)
        begin
            case (ph_addr)
                astc_pkg::OFF_CLOCK: hrdata[astc_pkg::DIV_LSB +: 4] = clk_div_sel;
                astc_pkg::OFF_TRIG:
                begin
                    hrdata[astc_pkg::TRG_START_LSB +: 3] = cfg.start_chan_sel;
                    hrdata[astc_pkg::TRG_END_LSB +: 3] = cfg.end_chan_sel;
                    hrdata[astc_pkg::TRG_MODE_BIT] = cfg.conv_mode_sel;
                    hrdata[astc_pkg::TRG_SRC_LSB +: 2] = cfg.trig_src_sel;
                    hrdata[astc_pkg::TRG_JUST_BIT] = cfg.justify_sel;
                    hrdata[astc_pkg::TRG_SMP_LSB +: 3] = cfg.sample_time_sel;
                end
                astc_pkg::OFF_CTRL:
                begin
                    hrdata[astc_pkg::CTL_EN_BIT] = conv_enable;
                    hrdata[astc_pkg::CTL_START_BIT] = conv_start_busy;
                    hrdata[astc_pkg::CTL_DONE_BIT] = conv_done_flag;
                    hrdata[astc_pkg::CTL_OVR_BIT] = overwrite_err_flag;
                    hrdata[astc_pkg::CTL_CHAN_LSB +: 3] = cur_chan;
                end
                astc_pkg::OFF_DATA: hrdata[15:0] = result_data;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_div_sel <= astc_pkg::DIV_RST;
            cfg.start_chan_sel <= astc_pkg::CHAN_RST;
            cfg.end_chan_sel <= astc_pkg::CHAN_RST;
            cfg.conv_mode_sel <= astc_pkg::MODE_RST;
            cfg.trig_src_sel <= astc_pkg::SRC_RST;
            cfg.justify_sel <= 1'b0;
            cfg.sample_time_sel <= astc_pkg::SMP_RST;
            conv_enable <= 1'b0;
        end
        else if (ph_valid && ph_write)
        begin
            if (ph_addr == astc_pkg::OFF_CLOCK)
                clk_div_sel <= hwdata[astc_pkg::DIV_LSB +: 4];
            if (ph_addr == astc_pkg::OFF_TRIG)
            begin
                cfg.start_chan_sel <= hwdata[astc_pkg::TRG_START_LSB +: 3];
                cfg.end_chan_sel <= hwdata[astc_pkg::TRG_END_LSB +: 3];
                cfg.conv_mode_sel <= hwdata[astc_pkg::TRG_MODE_BIT];
                cfg.trig_src_sel <= hwdata[astc_pkg::TRG_SRC_LSB +: 2];
                cfg.justify_sel <= hwdata[astc_pkg::TRG_JUST_BIT];
                cfg.sample_time_sel <= hwdata[astc_pkg::TRG_SMP_LSB +: 3];
            end
            if (wr_ctrl)
                conv_enable <= hwdata[astc_pkg::CTL_EN_BIT];
        end
    end

    // external trigger synchroniser and falling edge detect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
        end
        else
        begin
            ext_meta <= ext_trigger_n;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    assign sw_start = wr_ctrl && hwdata[astc_pkg::CTL_START_BIT];
    assign sw_stop = wr_ctrl && !hwdata[astc_pkg::CTL_START_BIT] && conv_start_busy;

    always_comb
    begin
        case (cfg.trig_src_sel)
            astc_pkg::SRC_SOFT: trigger = sw_start;
            astc_pkg::SRC_TIMER: trigger = timer16_underflow;
            astc_pkg::SRC_EXT: trigger = ext_prev && !ext_sync;
            default: trigger = 1'b0;
        endcase
        trigger = trigger && conv_enable && state == astc_pkg::ST_IDLE;
    end

    astc_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        // divider restarts per channel so sampling spans whole conversion clocks
        .run(state == astc_pkg::ST_SAMPLE || state == astc_pkg::ST_CONVERT),
        .div_sel(clk_div_sel),
        .tick(tick)
    );

    assign seq_last = cur_chan == cfg.end_chan_sel;

    // sequencer: sample, convert, store per channel
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= astc_pkg::ST_IDLE;
            phase_cnt <= 4'h0;
            cur_chan <= astc_pkg::CHAN_RST;
            conv_start_busy <= 1'b0;
        end
        else if (sw_stop || !conv_enable)
        begin
            state <= astc_pkg::ST_IDLE;
            conv_start_busy <= 1'b0;
            phase_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                astc_pkg::ST_IDLE:
                    if (trigger)
                    begin
                        state <= astc_pkg::ST_SAMPLE;
                        cur_chan <= cfg.start_chan_sel;
                        phase_cnt <= 4'h0;
                        conv_start_busy <= 1'b1;
                    end
                astc_pkg::ST_SAMPLE:
                    if (tick)
                    begin
                        if (phase_cnt == {1'b0, cfg.sample_time_sel} + astc_pkg::SMP_BASE - 4'h1)
                        begin
                            state <= astc_pkg::ST_CONVERT;
                            phase_cnt <= 4'h0;
                        end
                        else
                            phase_cnt <= phase_cnt + 4'h1;
                    end
                astc_pkg::ST_CONVERT:
                    if (tick)
                    begin
                        if (phase_cnt == astc_pkg::CONV_CYCLES - 4'h1)
                            state <= astc_pkg::ST_STORE;
                        else
                            phase_cnt <= phase_cnt + 4'h1;
                    end
                astc_pkg::ST_STORE:
                begin
                    phase_cnt <= 4'h0;
                    cur_chan <= cur_chan + 3'h1;
                    if (seq_last && !cfg.conv_mode_sel)
                    begin
                        state <= astc_pkg::ST_IDLE;
                        conv_start_busy <= 1'b0;
                    end
                    else
                    begin
                        state <= astc_pkg::ST_SAMPLE;
                        if (seq_last)
                            cur_chan <= cfg.start_chan_sel;
                    end
                end
                default: state <= astc_pkg::ST_IDLE;
            endcase
        end
    end

    assign store_val = (cur_chan > astc_pkg::LAST_REAL_CHAN) ? 10'h000 : analog_result;
    assign next_result = cfg.justify_sel ? {store_val, 6'h00} : {6'h00, store_val};

    // result and status flags; a set beats a same-cycle clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            result_data <= 16'h0000;
            conv_done_flag <= 1'b0;
            overwrite_err_flag <= 1'b0;
        end
        else if (state == astc_pkg::ST_STORE && !sw_stop && conv_enable)
        begin
            result_data <= next_result;
            conv_done_flag <= 1'b1;
            if (conv_done_flag && !rd_data)
                overwrite_err_flag <= 1'b1;
            else if (wr_ctrl && hwdata[astc_pkg::CTL_OVR_BIT])
                overwrite_err_flag <= 1'b0;
        end
        else
        begin
            if (rd_data)
                conv_done_flag <= 1'b0;
            if (wr_ctrl && hwdata[astc_pkg::CTL_OVR_BIT])
                overwrite_err_flag <= 1'b0;
        end
    end

    assign analog_chan = cur_chan;
    assign analog_sample = state == astc_pkg::ST_SAMPLE;
    assign analog_convert = state == astc_pkg::ST_CONVERT;

    a_one_time_stop: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && seq_last && !cfg.conv_mode_sel && conv_enable && !sw_stop
        |=> state == astc_pkg::ST_IDLE && !conv_start_busy)
        else $error("one-time sequence did not stop");
    a_cont_repeat: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && seq_last && cfg.conv_mode_sel && conv_enable && !sw_stop
        |=> state == astc_pkg::ST_SAMPLE && cur_chan == $past(cfg.start_chan_sel))
        else $error("continuous sequence did not restart");
    a_chan_wrap: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && !seq_last && conv_enable && !sw_stop
        |=> cur_chan == 3'($past(cur_chan) + 3'h1))
        else $error("channel did not step by one");
    a_start_chan: assert property (@(posedge clk) disable iff (rst)
        trigger && !sw_stop |=> cur_chan == $past(cfg.start_chan_sel) && conv_start_busy)
        else $error("sequence did not begin at start channel");
    a_empty_chan: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && cur_chan > 3'h3 && conv_enable && !sw_stop
        |=> result_data == 16'h0000)
        else $error("missing channel stored nonzero");
    a_justify: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && conv_enable && !sw_stop && cfg.justify_sel
        |=> result_data[5:0] == 6'h00)
        else $error("left justified result low bits nonzero");
    a_overwrite: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && conv_enable && !sw_stop && conv_done_flag && !rd_data
        |=> overwrite_err_flag)
        else $error("overwrite flag not set");
    a_abort_now: assert property (@(posedge clk) disable iff (rst)
        sw_stop |=> state == astc_pkg::ST_IDLE && $stable(result_data))
        else $error("abort did not stop at once");
    a_gated_trig: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_IDLE && !conv_enable |=> state == astc_pkg::ST_IDLE)
        else $error("sequence began while disabled");
    a_reserved_src: assert property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_IDLE && cfg.trig_src_sel == 2'h2 |=> state == astc_pkg::ST_IDLE)
        else $error("reserved source started a sequence");
    c_ext_start: cover property (@(posedge clk) disable iff (rst)
        trigger && cfg.trig_src_sel == astc_pkg::SRC_EXT);
    c_wrap: cover property (@(posedge clk) disable iff (rst)
        state == astc_pkg::ST_STORE && cur_chan == 3'h7 && !seq_last);
    c_overrun: cover property (@(posedge clk) disable iff (rst) $rose(overwrite_err_flag));
    c_abort: cover property (@(posedge clk) disable iff (rst)
        sw_stop && state == astc_pkg::ST_CONVERT);
endmodule

// [hdl/astc_pkg.sv]
// shared constants and types for the converter sequence/trigger control
package astc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CLOCK = 8'h00;
    localparam logic [7:0] OFF_TRIG = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    // conv_clock_reg fields
    localparam int DIV_LSB = 0;
    // trigger_config_reg fields
    localparam int TRG_START_LSB = 0;
    localparam int TRG_END_LSB = 3;
    localparam int TRG_MODE_BIT = 6;
    localparam int TRG_SRC_LSB = 8;
    localparam int TRG_JUST_BIT = 10;
    localparam int TRG_SMP_LSB = 12;
    // conv_control_reg fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_START_BIT = 1;
    localparam int CTL_DONE_BIT = 2;
    localparam int CTL_OVR_BIT = 3;
    localparam int CTL_CHAN_LSB = 4;
    // reset values, the reserved divider code and the sampling-time base
    localparam logic [3:0] DIV_RST = 4'h0;
    localparam logic [3:0] DIV_RESERVED = 4'hF;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic MODE_RST = 1'b0;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [2:0] SMP_RST = 3'h7;
    localparam logic [3:0] SMP_BASE = 4'h2;
    // trigger source codes
    localparam logic [1:0] SRC_SOFT = 2'h0;
    localparam logic [1:0] SRC_TIMER = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // analog channels present
    localparam logic [2:0] LAST_REAL_CHAN = 3'h3;
    // conversion clocks of the approximation phase
    localparam logic [3:0] CONV_CYCLES = 4'hB;
    localparam int RES_BITS = 10;

    typedef struct packed {
        logic [2:0] start_chan_sel;
        logic [2:0] end_chan_sel;
        logic conv_mode_sel;
        logic [1:0] trig_src_sel;
        logic justify_sel;
        logic [2:0] sample_time_sel;
    } astc_cfg_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_STORE = 4'b1000
    } astc_state_e;
endpackage

// [hdl/astc_clkdiv.sv]
// divides the bus clock into a one-cycle conversion clock enable
`timescale 1ns/1ps
module astc_clkdiv (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [3:0] div_sel,
    output logic tick
);
    logic [14:0] cnt;
    logic [14:0] limit;

    // ratio 1/2 at code 0 doubling to 1/32768 at code 0xE; 0xF stops the clock
    always_comb
    begin
        limit = 15'((32'h2 << div_sel) - 32'h1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= 15'h0000;
        else if (!run || div_sel == astc_pkg::DIV_RESERVED)
            cnt <= 15'h0000;
        else if (cnt >= limit)
            cnt <= 15'h0000;
        else
            cnt <= cnt + 15'h0001;
    end

    assign tick = run && div_sel != astc_pkg::DIV_RESERVED && cnt >= limit;
endmodule

// [testbench/astc_partner.sv]
// model of the converter core, the timer underflow and the external trigger pin
`timescale 1ns/1ps
module astc_partner (
    input wire logic clk,
    input wire logic [2:0] analog_chan,
    input wire logic analog_sample,
    input wire logic analog_convert,
    output logic [9:0] analog_result,
    output logic ext_trigger_n,
    output logic timer16_underflow
);
    logic conv_q = 1'b0;
    logic [9:0] res;
    initial
    begin
        ext_trigger_n = 1'b1;
        timer16_underflow = 1'b0;
    end
    always @(posedge clk) conv_q <= analog_convert;
    assign res = {analog_chan, 4'hA, analog_chan};
    // result only valid while converting and in the store cycle
    assign analog_result = (analog_convert || conv_q) ? res : ~res;
    task fire_timer();
        @(posedge clk);
        timer16_underflow <= 1'b1;
        @(posedge clk);
        timer16_underflow <= 1'b0;
    endtask
    task pulse_ext();
        @(posedge clk);
        ext_trigger_n <= 1'b0;
        repeat (3) @(posedge clk);
        ext_trigger_n <= 1'b1;
    endtask
endmodule

// [testbench/astc_top_tb_top.sv]
// register-level tests of the converter sequence and trigger control
`timescale 1ns/1ps
module astc_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic ext_trigger_n;
    logic timer16_underflow;
    logic [9:0] analog_result;
    logic [2:0] analog_chan;
    logic analog_sample;
    logic analog_convert;
    logic conv_q = 1'b0;
    logic [2:0] chans[$];
    int scnt = 0;
    int slen = 0;
    int n_mismatch = 0;
    int checks_done = 0;
    int exp_n;
    logic [2:0] wrap[8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
    always #50 clk = ~clk;
    assign hready = hreadyout;
    astc_top astc_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_trigger_n(ext_trigger_n),
        .timer16_underflow(timer16_underflow), .analog_result(analog_result),
        .analog_chan(analog_chan), .analog_sample(analog_sample),
        .analog_convert(analog_convert));
    astc_partner astc_partner_i (.clk(clk), .analog_chan(analog_chan),
        .analog_sample(analog_sample), .analog_convert(analog_convert),
        .analog_result(analog_result), .ext_trigger_n(ext_trigger_n),
        .timer16_underflow(timer16_underflow));
    // record channel at each store cycle and length of each sampling phase
    always @(posedge clk)
    begin
        conv_q <= analog_convert;
        if (conv_q && !analog_convert) chans.push_back(analog_chan);
        if (analog_sample) scnt++;
        else if (scnt != 0)
        begin
            slen = scnt;
            scnt = 0;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ahb_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsel <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        hsel <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        do @(posedge clk); while (hready !== 1'b1);
        chk(hrdata & mask, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task cfg(input logic [2:0] s, input logic [2:0] e, input logic m, input logic [1:0] src,
        input logic j, input logic [2:0] smp, input logic [3:0] div);
        ahb_write(astc_pkg::OFF_CTRL, 32'h0);
        ahb_write(astc_pkg::OFF_CLOCK, {28'h0, div});
        ahb_write(astc_pkg::OFF_TRIG, {17'h0, smp, 1'b0, j, src, 1'b0, m, e, s});
        ahb_write(astc_pkg::OFF_CTRL, 32'h1);
        chans.delete();
    endtask
    task wait_chans(input int n);
        int k;
        k = 0;
        while (chans.size() < n && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    task run_done(input int n);
        ahb_write(astc_pkg::OFF_CTRL, 32'h3);
        wait_chans(n);
        repeat (4) @(posedge clk);
        rd(astc_pkg::OFF_CTRL, 32'h2, 32'h0);
        chk(32'(chans.size()), 32'(n));
    endtask
    task test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #(30000 * 100);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(astc_pkg::OFF_CLOCK, 32'hFFFF_FFFF, 32'h0);
        rd(astc_pkg::OFF_TRIG, 32'hFFFF_FFFF, 32'h7000);
        rd(astc_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd(astc_pkg::OFF_DATA, 32'hFFFF_FFFF, 32'h0);
        rd(8'h10, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
        cfg(3'h0, 3'h0, 1'b0, astc_pkg::SRC_SOFT, 1'b0, 3'h0, 4'h0);
        run_done(1);
        chk({29'h0, chans[0]}, 32'h0);
        chk(32'(slen), 32'h4);
        rd(astc_pkg::OFF_CTRL, 32'h4, 32'h4);
        rd(astc_pkg::OFF_DATA, 32'hFFFF_FFFF, 32'h0050);
        rd(astc_pkg::OFF_CTRL, 32'h4, 32'h0);
        $display("test single channel done");
        cfg(3'h2, 3'h1, 1'b0, astc_pkg::SRC_SOFT, 1'b1, 3'h7, 4'h0);
        run_done(8);
        for (int i = 0; i < 8; i++) chk({29'h0, chans[i]}, {29'h0, wrap[i]});
        chk(32'(slen), 32'd18);
        rd(astc_pkg::OFF_DATA, 32'hFFFF_FFFF, 32'h3440);
        rd(astc_pkg::OFF_CTRL, 32'h8, 32'h8);
        ahb_write(astc_pkg::OFF_CTRL, 32'h9);
        rd(astc_pkg::OFF_CTRL, 32'h8, 32'h0);
        $display("test wrap done");
        cfg(3'h5, 3'h5, 1'b0, astc_pkg::SRC_SOFT, 1'b0, 3'h0, 4'h1);
        run_done(1);
        chk(32'(slen), 32'h8);
        rd(astc_pkg::OFF_DATA, 32'hFFFF_FFFF, 32'h0);
        $display("test empty channel done");
        for (int s = 0; s < 4; s++)
        begin
            cfg(3'h3, 3'h3, 1'b0, 2'(s), 1'b0, 3'h0, 4'h0);
            exp_n = 0;
            for (int k = 0; k < 3; k++)
            begin
                if (k == 0) ahb_write(astc_pkg::OFF_CTRL, 32'h3);
                else if (k == 1) astc_partner_i.fire_timer();
                else astc_partner_i.pulse_ext();
                if (((k == 2) ? 3 : k) == s) exp_n++;
                repeat (60) @(posedge clk);
                chk(32'(chans.size()), 32'(exp_n));
            end
        end
        cfg(3'h0, 3'h0, 1'b0, astc_pkg::SRC_SOFT, 1'b0, 3'h0, 4'h0);
        ahb_write(astc_pkg::OFF_CTRL, 32'h0);
        ahb_write(astc_pkg::OFF_CTRL, 32'h2);
        rd(astc_pkg::OFF_CTRL, 32'h2, 32'h0);
        repeat (60) @(posedge clk);
        chk(32'(chans.size()), 32'h0);
        $display("test trigger sources done");
        cfg(3'h0, 3'h1, 1'b1, astc_pkg::SRC_SOFT, 1'b0, 3'h0, 4'h0);
        ahb_write(astc_pkg::OFF_CTRL, 32'h3);
        wait_chans(3);
        chk({29'h0, chans[0]}, 32'h0);
        chk({29'h0, chans[1]}, 32'h1);
        chk({29'h0, chans[2]}, 32'h0);
        ahb_write(astc_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk({30'h0, analog_sample, analog_convert}, 32'h0);
        rd(astc_pkg::OFF_CTRL, 32'h2, 32'h0);
        exp_n = chans.size();
        repeat (60) @(posedge clk);
        chk(32'(chans.size()), 32'(exp_n));
        $display("test continuous done");
        test_done();
    end
endmodule
